// ===== design/sgoq_pkg.sv
// Package with the field layout, command codes and constants of the status groups block
package sgoq_pkg;
  localparam int SGOQ_W = 16;
  localparam int SGOQ_NGRP = 3;
  // Group selector codes
  localparam logic [1:0] SGOQ_GRP_OPER = 2'h0;
  localparam logic [1:0] SGOQ_GRP_POW = 2'h1;
  localparam logic [1:0] SGOQ_GRP_QUES = 2'h2;
  // Register selector codes within a group
  localparam logic [2:0] SGOQ_REG_COND = 3'h0;
  localparam logic [2:0] SGOQ_REG_PTR = 3'h1;
  localparam logic [2:0] SGOQ_REG_NTR = 3'h2;
  localparam logic [2:0] SGOQ_REG_EVEN = 3'h3;
  localparam logic [2:0] SGOQ_REG_ENAB = 3'h4;
  // Implemented bits per group; bit 15 and unused bits stay zero
  localparam logic [15:0] SGOQ_MASK_OPER = 16'h5f15;
  localparam logic [15:0] SGOQ_MASK_POW = 16'h0007;
  localparam logic [15:0] SGOQ_MASK_QUES = 16'h2108;
  // Reset values
  localparam logic [15:0] SGOQ_PTR_RST = 16'h7fff;
  localparam logic [15:0] SGOQ_NTR_RST = 16'h0000;
  localparam logic [15:0] SGOQ_ENAB_RST = 16'h0000;
  // Bit positions
  localparam int SGOQ_POW_FREQ_BIT = 0;
  localparam int SGOQ_POW_BELOW_BIT = 1;
  localparam int SGOQ_POW_ABOVE_BIT = 2;
  localparam int SGOQ_QUES_POW_BIT = 3;
  localparam int SGOQ_QUES_CAL_BIT = 8;
  localparam int SGOQ_QUES_INDET_BIT = 13;
  localparam int SGOQ_STB_QUES_BIT = 3;
  localparam int SGOQ_STB_AVAIL_BIT = 4;
  localparam int SGOQ_STB_OPER_BIT = 7;
  // Temperature drift limit in degrees C
  localparam logic signed [16:0] SGOQ_TEMP_DRIFT_C = 17'sd10;
  localparam int SGOQ_OQ_DEPTH = 2;
endpackage

// ===== design/sgoq_status_groups.sv
// Status register groups (operation, power, questionable) with the output queue
`timescale 1ns/1ps
// How it works
// [R1] Event register clears when queried and when the clear-status pulse arrives.
// [R2] Positive and negative transition filters are each readable by their own query.
// [R3] A filter write stores the integer as the new filter setting.
// [R4] Enable register is written, read back and held until rewritten.
// [R5] Response words stay queued until read or the queue is cleared.
// [R6] Queue hands words out first-in first-out and gives a message-available summary.
// [R7] Message-available is high while the queue holds data, low when empty.
// [R8] Later commands are held off while pending response data fills the queue.
// [R9] Power bit 2 set while temperature exceeds calibration temperature by over 10 C.
// [R10] Power bit 1 set while temperature is over 10 C below calibration temperature.
// [R11] Power bit 0 set while no calibration exists at the current frequency.
// [R12] Bit 15 and all unassigned bits of every group register read zero.
// [R13] Questionable group summary drives status byte bit 3.
// [R14] Questionable group takes the calibration group summary as an input.
// [R15] Questionable bit 3 carries the power group summary.
// [R16] Operation group summary drives status byte bit 7.
// [R17] Event bit latches on filtered rising or falling edges of its condition bit.
// [R18] Group summary is the OR of event bits ANDed with enable bits.
// [R19] Condition register tracks live inputs; reading it changes nothing else.
module sgoq_status_groups #(
  parameter int DEPTH = sgoq_pkg::SGOQ_OQ_DEPTH // Output queue entries
) (
  input wire logic ref_clk, // 40 MHz system clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [sgoq_pkg::SGOQ_W-1:0] oper_cond_in, // Operation condition sources
  input wire logic signed [15:0] temp_now, // Present temperature, degrees C
  input wire logic signed [15:0] temp_cal, // Temperature at calibration, degrees C
  input wire logic freq_uncal, // No power calibration at current frequency
  input wire logic cal_group_summary_bit, // Calibration group summary message
  input wire logic indet_result, // Indeterminate measurement result
  input wire logic cmd_valid, // Status command offered
  output logic cmd_ready, // Command can be taken this cycle
  input wire logic cmd_write, // 1 = write, 0 = query
  input wire logic [1:0] cmd_group, // Group selector
  input wire logic [2:0] cmd_reg, // Register selector
  input wire logic [sgoq_pkg::SGOQ_W-1:0] cmd_wdata, // Integer written
  input wire logic clear_status, // Clear-status pulse
  input wire logic oq_clear, // Output queue clear pulse
  output logic resp_valid, // Head of output queue valid
  input wire logic resp_ready, // Controller takes the head word
  output logic [sgoq_pkg::SGOQ_W-1:0] resp_data, // Head of output queue
  output logic message_available_flag, // Status byte bit 4
  output logic stb_ques_summary, // Status byte bit 3
  output logic stb_oper_summary // Status byte bit 7
);
  import sgoq_pkg::*;

  typedef logic [SGOQ_W-1:0] sgoq_word_t;

  // Implemented-bit mask for a group
  function automatic sgoq_word_t sgoq_mask(input int g);
    case (g)
      0: sgoq_mask = SGOQ_MASK_OPER;
      1: sgoq_mask = SGOQ_MASK_POW;
      2: sgoq_mask = SGOQ_MASK_QUES;
      default: sgoq_mask = '0;
    endcase
  endfunction

  // Two-flop synchronisers for everything arriving from outside the clock domain
  sgoq_word_t oper_s1_q, oper_s2_q;
  logic signed [15:0] tnow_s1_q, tnow_s2_q, tcal_s1_q, tcal_s2_q;
  logic [2:0] misc_s1_q, misc_s2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      oper_s1_q <= '0;
      oper_s2_q <= '0;
      tnow_s1_q <= '0;
      tnow_s2_q <= '0;
      tcal_s1_q <= '0;
      tcal_s2_q <= '0;
      misc_s1_q <= '0;
      misc_s2_q <= '0;
    end else begin
      oper_s1_q <= oper_cond_in;
      oper_s2_q <= oper_s1_q;
      tnow_s1_q <= temp_now;
      tnow_s2_q <= tnow_s1_q;
      tcal_s1_q <= temp_cal;
      tcal_s2_q <= tcal_s1_q;
      misc_s1_q <= {indet_result, cal_group_summary_bit, freq_uncal};
      misc_s2_q <= misc_s1_q;
    end
  end

  // Temperature drift; 17 bits so the difference cannot wrap
  wire logic signed [16:0] drift = 17'(tnow_s2_q) - 17'(tcal_s2_q);
  wire logic pow_above = drift > SGOQ_TEMP_DRIFT_C; // R9
  wire logic pow_below = drift < -SGOQ_TEMP_DRIFT_C; // R10

  // Group registers, one set per group
  sgoq_word_t cond [SGOQ_NGRP];
  sgoq_word_t prev_q [SGOQ_NGRP];
  sgoq_word_t ptr_q [SGOQ_NGRP];
  sgoq_word_t ntr_q [SGOQ_NGRP];
  sgoq_word_t ev_q [SGOQ_NGRP];
  sgoq_word_t en_q [SGOQ_NGRP];
  logic [SGOQ_NGRP-1:0] group_summary_bit;

  // Live condition words; the power summary feeds the questionable group
  sgoq_word_t pow_raw, ques_raw;
  always_comb begin
    pow_raw = '0;
    pow_raw[SGOQ_POW_FREQ_BIT] = misc_s2_q[0]; // R11
    pow_raw[SGOQ_POW_BELOW_BIT] = pow_below; // R10
    pow_raw[SGOQ_POW_ABOVE_BIT] = pow_above; // R9
    ques_raw = '0;
    ques_raw[SGOQ_QUES_POW_BIT] = group_summary_bit[1]; // R15
    ques_raw[SGOQ_QUES_CAL_BIT] = misc_s2_q[1]; // R14
    ques_raw[SGOQ_QUES_INDET_BIT] = misc_s2_q[2];
  end
  assign cond[0] = oper_s2_q & SGOQ_MASK_OPER; // R12 R19
  assign cond[1] = pow_raw & SGOQ_MASK_POW; // R12 R19
  assign cond[2] = ques_raw & SGOQ_MASK_QUES; // R12 R19

  // Command acceptance and decode
  logic cmd_ready_q;
  wire logic take = cmd_valid && cmd_ready_q;
  wire logic take_wr = take && cmd_write;
  wire logic take_rd = take && !cmd_write;

  genvar g;
  generate
    for (g = 0; g < SGOQ_NGRP; g++) begin : g_grp
      wire logic hit = (cmd_group == 2'(g));
      wire logic wr_ptr = take_wr && hit && (cmd_reg == SGOQ_REG_PTR);
      wire logic wr_ntr = take_wr && hit && (cmd_reg == SGOQ_REG_NTR);
      wire logic wr_en = take_wr && hit && (cmd_reg == SGOQ_REG_ENAB);
      wire logic rd_ev = take_rd && hit && (cmd_reg == SGOQ_REG_EVEN);
      // Filtered edges; a new edge beats a clear in the same cycle
      wire sgoq_word_t ev_set = (cond[g] & ~prev_q[g] & ptr_q[g]) |
                                (~cond[g] & prev_q[g] & ntr_q[g]); // R17
      wire logic ev_clr = rd_ev || clear_status; // R1
      assign group_summary_bit[g] = |(ev_q[g] & en_q[g]); // R18
      // Filter, enable and event storage
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_q[g] <= '0;
          ptr_q[g] <= SGOQ_PTR_RST & sgoq_mask(g);
          ntr_q[g] <= SGOQ_NTR_RST;
          en_q[g] <= SGOQ_ENAB_RST;
          ev_q[g] <= '0;
        end else begin
          prev_q[g] <= cond[g];
          if (wr_ptr) ptr_q[g] <= cmd_wdata & sgoq_mask(g); // R3 R12
          if (wr_ntr) ntr_q[g] <= cmd_wdata & sgoq_mask(g); // R3 R12
          if (wr_en) en_q[g] <= cmd_wdata & sgoq_mask(g); // R4 R12
          ev_q[g] <= ((ev_clr ? '0 : ev_q[g]) | ev_set) & sgoq_mask(g); // R1 R17
        end
      end
    end
  endgenerate

  // Query answer mux; reading condition or filters has no side effect
  sgoq_word_t rd_word;
  always_comb begin
    rd_word = '0;
    if (cmd_group < 2'(SGOQ_NGRP)) begin
      case (cmd_reg)
        SGOQ_REG_COND: rd_word = cond[cmd_group]; // R19
        SGOQ_REG_PTR: rd_word = ptr_q[cmd_group]; // R2
        SGOQ_REG_NTR: rd_word = ntr_q[cmd_group]; // R2
        SGOQ_REG_EVEN: rd_word = ev_q[cmd_group];
        SGOQ_REG_ENAB: rd_word = en_q[cmd_group]; // R4
        default: rd_word = '0;
      endcase
    end
  end

  // Output queue: shift buffer, head always in slot 0 so outputs come from flops.
  // Depth is small, so shifting costs little and avoids a read mux on the output.
  localparam int CW = $clog2(DEPTH + 1);
  sgoq_word_t mem_q [DEPTH];
  logic [CW-1:0] cnt_q, cnt_d;
  logic resp_valid_q, msg_avail_q, ques_q, oper_q;
  wire logic pop = resp_valid_q && resp_ready && !oq_clear; // R6
  wire logic push = take_rd && !oq_clear; // R5
  wire logic [CW-1:0] wr_idx = cnt_q - CW'(pop);
  always_comb begin
    cnt_d = cnt_q;
    if (oq_clear) cnt_d = '0;
    else if (push && !pop) cnt_d = cnt_q + CW'(1);
    else if (pop && !push) cnt_d = cnt_q - CW'(1);
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      wire sgoq_word_t above = (i + 1 < DEPTH) ? mem_q[(i + 1) % DEPTH] : '0;
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) mem_q[i] <= '0;
        else if (push && wr_idx == CW'(i)) mem_q[i] <= rd_word; // R5 R6
        else if (pop) mem_q[i] <= above; // R6
      end
    end
  endgenerate

  // Queue count, flags and status byte summaries, all registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      cmd_ready_q <= 1'b0;
      resp_valid_q <= 1'b0;
      msg_avail_q <= 1'b0;
      ques_q <= 1'b0;
      oper_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      cmd_ready_q <= (cnt_d != CW'(DEPTH)); // R8
      resp_valid_q <= (cnt_d != '0); // R6
      msg_avail_q <= (cnt_d != '0); // R7
      ques_q <= group_summary_bit[2]; // R13
      oper_q <= group_summary_bit[0]; // R16
    end
  end

  assign cmd_ready = cmd_ready_q;
  assign resp_valid = resp_valid_q;
  assign resp_data = mem_q[0];
  assign message_available_flag = msg_avail_q;
  assign stb_ques_summary = ques_q;
  assign stb_oper_summary = oper_q;

  // Checks on the design's own behaviour
  property p_ev_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      (clear_status && !oq_clear && cond[2] == prev_q[2]) |=> (ev_q[2] == '0);
  endproperty
  a_ev_clear: assert property (p_ev_clear) else $error("event not cleared"); // R1

  property p_ptr_store;
    @(posedge ref_clk) disable iff (!rst_n)
      (take_wr && cmd_group == SGOQ_GRP_POW && cmd_reg == SGOQ_REG_PTR)
      |=> (ptr_q[1] == ($past(cmd_wdata) & SGOQ_MASK_POW));
  endproperty
  a_ptr_store: assert property (p_ptr_store) else $error("filter not stored"); // R3

  property p_en_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !(take_wr && cmd_group == SGOQ_GRP_OPER && cmd_reg == SGOQ_REG_ENAB)
      |=> $stable(en_q[0]);
  endproperty
  a_en_hold: assert property (p_en_hold) else $error("enable changed"); // R4

  property p_msg_avail;
    @(posedge ref_clk) disable iff (!rst_n)
      message_available_flag == (cnt_q != '0);
  endproperty
  a_msg_avail: assert property (p_msg_avail) else $error("message-available mismatch"); // R7

  property p_full_stall;
    @(posedge ref_clk) disable iff (!rst_n)
      (cnt_q == CW'(DEPTH)) |-> !cmd_ready;
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("accepted while full"); // R8

  property p_hold_head;
    @(posedge ref_clk) disable iff (!rst_n)
      (resp_valid && !resp_ready && !oq_clear) |=> (resp_valid && $stable(resp_data));
  endproperty
  a_hold_head: assert property (p_hold_head) else $error("head word lost"); // R5

  property p_above;
    @(posedge ref_clk) disable iff (!rst_n)
      cond[1][SGOQ_POW_ABOVE_BIT] ==
        (int'(tnow_s2_q) - int'(tcal_s2_q) > int'(SGOQ_TEMP_DRIFT_C));
  endproperty
  a_above: assert property (p_above) else $error("above-temperature bit wrong"); // R9

  property p_below;
    @(posedge ref_clk) disable iff (!rst_n)
      cond[1][SGOQ_POW_BELOW_BIT] ==
        (int'(tnow_s2_q) - int'(tcal_s2_q) < -int'(SGOQ_TEMP_DRIFT_C));
  endproperty
  a_below: assert property (p_below) else $error("below-temperature bit wrong"); // R10

  property p_bit15;
    @(posedge ref_clk) disable iff (!rst_n)
      !ev_q[0][15] && !en_q[2][15] && !ptr_q[1][15] && !resp_data[15];
  endproperty
  a_bit15: assert property (p_bit15) else $error("bit 15 set"); // R12

  property p_ques_sum;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (stb_ques_summary == $past(|(ev_q[2] & en_q[2])));
  endproperty
  a_ques_sum: assert property (p_ques_sum) else $error("questionable summary wrong"); // R13 R18

  property p_edge_latch;
    @(posedge ref_clk) disable iff (!rst_n)
      (cond[0][0] && !prev_q[0][0] && ptr_q[0][0]) |=> ev_q[0][0];
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("rising edge not latched"); // R17

  property p_ev_query;
    @(posedge ref_clk) disable iff (!rst_n)
      (take_rd && cmd_group == SGOQ_GRP_POW && cmd_reg == SGOQ_REG_EVEN && cond[1] == prev_q[1])
      |=> (ev_q[1] == '0);
  endproperty
  a_ev_query: assert property (p_ev_query) else $error("event not cleared by query"); // R1

  property p_filter_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (take_rd && !oq_clear && cmd_group == SGOQ_GRP_QUES && cmd_reg == SGOQ_REG_NTR &&
       cnt_q == '0) |=> (resp_data == $past(ntr_q[2]));
  endproperty
  a_filter_read: assert property (p_filter_read) else $error("filter query wrong"); // R2

  property p_cond_read;
    @(posedge ref_clk) disable iff (!rst_n)
      (take_rd && cmd_reg == SGOQ_REG_COND)
      |=> ($stable(ptr_q[0]) && $stable(ntr_q[0]) && $stable(en_q[0]));
  endproperty
  a_cond_read: assert property (p_cond_read) else $error("query side effect"); // R19

  // The sync pipe is two deep, so input and condition agree only two edges after reset
  property p_freq_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> (cond[1][SGOQ_POW_FREQ_BIT] == $past(freq_uncal, 2));
  endproperty
  a_freq_bit: assert property (p_freq_bit) else $error("frequency bit wrong"); // R11

  property p_ques_inputs;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n, 2) |-> (cond[2][SGOQ_QUES_CAL_BIT] == $past(cal_group_summary_bit, 2));
  endproperty
  a_ques_inputs: assert property (p_ques_inputs) else $error("calibration bit wrong"); // R14

  property p_ques_pow;
    @(posedge ref_clk) disable iff (!rst_n)
      cond[2][SGOQ_QUES_POW_BIT] == |(ev_q[1] & en_q[1]);
  endproperty
  a_ques_pow: assert property (p_ques_pow) else $error("power summary missing"); // R15 R18

  property p_oper_sum;
    @(posedge ref_clk) disable iff (!rst_n)
      1'b1 |=> (stb_oper_summary == $past(|(ev_q[0] & en_q[0])));
  endproperty
  a_oper_sum: assert property (p_oper_sum) else $error("operation summary wrong"); // R16 R18

  property p_fifo_order;
    @(posedge ref_clk) disable iff (!rst_n)
      (pop && cnt_q > CW'(1)) |=> (resp_valid && resp_data == $past(mem_q[1 % DEPTH]));
  endproperty
  a_fifo_order: assert property (p_fifo_order) else $error("queue order broken"); // R6

  property p_queue_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      oq_clear |=> (!resp_valid && !message_available_flag);
  endproperty
  a_queue_clear: assert property (p_queue_clear) else $error("queue not emptied"); // R5 R7
endmodule // sgoq_status_groups

// ===== bench/sgoq_ctrl_model.sv
// Remote controller model: issues status commands and collects response words
`timescale 1ns/1ps
module sgoq_ctrl_model (
  input wire logic ref_clk, // System clock
  input wire logic cmd_ready, // Device can take a command
  output logic cmd_valid, // Command offered
  output logic cmd_write, // 1 = write
  output logic [1:0] cmd_group, // Group selector
  output logic [2:0] cmd_reg, // Register selector
  output logic [15:0] cmd_wdata, // Integer written
  input wire logic resp_valid, // Response word valid
  output logic resp_ready, // Take response word
  input wire logic [15:0] resp_data // Response word
);
  logic stall = 1'b0;
  logic [15:0] got[$];
  initial begin
    {cmd_valid, cmd_write, cmd_group, cmd_reg, cmd_wdata} = '0;
  end
  // Ready is registered, so seen high at a falling edge it holds at the next rising one
  task automatic send(input logic w, input logic [1:0] g, input logic [2:0] r,
                      input logic [15:0] d);
    @(negedge ref_clk);
    {cmd_valid, cmd_write, cmd_group, cmd_reg, cmd_wdata} = {1'b1, w, g, r, d};
    while (!cmd_ready) @(negedge ref_clk);
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    cmd_wdata = ~d; // Released data never keeps the last value
  endtask
  // Slow mode holds off reading so words pile up in the device
  // Stall only changes at falling edges, so ready follows it there without a race
  assign resp_ready = !stall;
  always @(posedge ref_clk) if (resp_valid && resp_ready) got.push_back(resp_data);
endmodule // sgoq_ctrl_model

// ===== bench/testbench.sv
// Self-checking testbench for the status groups and output queue
`timescale 1ns/1ps
module testbench;
  import sgoq_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] oper_cond_in = 16'h0000;
  logic signed [15:0] temp_now = 16'sh14;
  logic signed [15:0] temp_cal = 16'sh14;
  logic freq_uncal = 1'b0;
  logic cal_group_summary_bit = 1'b0;
  logic indet_result = 1'b0;
  logic clear_status = 1'b0;
  logic oq_clear = 1'b0;
  logic cmd_valid, cmd_ready, cmd_write, resp_valid, resp_ready;
  logic message_available_flag, stb_ques_summary, stb_oper_summary;
  logic [1:0] cmd_group;
  logic [2:0] cmd_reg;
  logic [15:0] cmd_wdata, resp_data;
  logic [15:0] masks [3] = '{SGOQ_MASK_OPER, SGOQ_MASK_POW, SGOQ_MASK_QUES};
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  sgoq_status_groups #(.DEPTH(2)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .oper_cond_in(oper_cond_in), .temp_now(temp_now), .temp_cal(temp_cal),
    .freq_uncal(freq_uncal), .cal_group_summary_bit(cal_group_summary_bit),
    .indet_result(indet_result),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write),
    .cmd_group(cmd_group), .cmd_reg(cmd_reg), .cmd_wdata(cmd_wdata),
    .clear_status(clear_status), .oq_clear(oq_clear), .resp_valid(resp_valid),
    .resp_ready(resp_ready), .resp_data(resp_data),
    .message_available_flag(message_available_flag),
    .stb_ques_summary(stb_ques_summary), .stb_oper_summary(stb_oper_summary));
  sgoq_ctrl_model ctrl (.ref_clk(ref_clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_group(cmd_group), .cmd_reg(cmd_reg),
    .cmd_wdata(cmd_wdata), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_data(resp_data));
  // Compare, count and report
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Bounded wait for the next response word
  task automatic chkpop(input logic [15:0] exp);
    for (int i = 0; i < 100 && ctrl.got.size() == 0; i++) @(negedge ref_clk);
    chk((ctrl.got.size() > 0) ? ctrl.got.pop_front() : 16'hxxxx, exp);
  endtask
  task automatic q(input logic [1:0] g, input logic [2:0] r, input logic [15:0] exp);
    ctrl.send(1'b0, g, r, 16'h0000);
    chkpop(exp);
  endtask
  task automatic w(input logic [1:0] g, input logic [2:0] r, input logic [15:0] d);
    ctrl.send(1'b1, g, r, d);
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Cut a hang short well past the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    settle(3);
    rst_n = 1'b1;
    for (int g = 0; g < 3; g++) begin
      q(g[1:0], SGOQ_REG_PTR, masks[g]);
      q(g[1:0], SGOQ_REG_NTR, 16'h0000);
      q(g[1:0], SGOQ_REG_ENAB, 16'h0000);
      w(g[1:0], SGOQ_REG_PTR, 16'haaaa);
      w(g[1:0], SGOQ_REG_NTR, 16'hd555);
      w(g[1:0], SGOQ_REG_ENAB, 16'hffff);
      q(g[1:0], SGOQ_REG_PTR, masks[g] & 16'haaaa);
      q(g[1:0], SGOQ_REG_NTR, masks[g] & 16'h5555);
      q(g[1:0], SGOQ_REG_ENAB, masks[g]);
      w(g[1:0], SGOQ_REG_PTR, 16'hffff);
      w(g[1:0], SGOQ_REG_NTR, 16'h0000);
      w(g[1:0], SGOQ_REG_ENAB, 16'h0000);
    end
    q(2'h3, SGOQ_REG_COND, 16'h0000);
    q(SGOQ_GRP_OPER, 3'h7, 16'h0000);
    // Temperature drift both ways, the exact limit, and uncalibrated frequency
    temp_now = 16'sh1f;
    settle(6);
    q(SGOQ_GRP_POW, SGOQ_REG_COND, 16'h0004);
    q(SGOQ_GRP_POW, SGOQ_REG_EVEN, 16'h0004);
    q(SGOQ_GRP_POW, SGOQ_REG_EVEN, 16'h0000);
    temp_now = 16'sh9;
    settle(6);
    q(SGOQ_GRP_POW, SGOQ_REG_COND, 16'h0002);
    temp_now = 16'sh1e;
    freq_uncal = 1'b1;
    settle(6);
    q(SGOQ_GRP_POW, SGOQ_REG_COND, 16'h0001);
    q(SGOQ_GRP_POW, SGOQ_REG_EVEN, 16'h0003);
    // Power summary feeds the questionable group, which feeds the status byte
    w(SGOQ_GRP_POW, SGOQ_REG_ENAB, 16'h0001);
    freq_uncal = 1'b0;
    settle(6);
    freq_uncal = 1'b1;
    cal_group_summary_bit = 1'b1;
    indet_result = 1'b1;
    settle(8);
    q(SGOQ_GRP_QUES, SGOQ_REG_COND, 16'h2108);
    w(SGOQ_GRP_QUES, SGOQ_REG_ENAB, 16'h0008);
    settle(4);
    chk(stb_ques_summary, 1'b1);
    clear_status = 1'b1;
    settle(1);
    clear_status = 1'b0;
    settle(6);
    chk(stb_ques_summary, 1'b0);
    q(SGOQ_GRP_QUES, SGOQ_REG_EVEN, 16'h0000);
    // Only the falling edge is let through on the operation group
    w(SGOQ_GRP_OPER, SGOQ_REG_PTR, 16'h0000);
    w(SGOQ_GRP_OPER, SGOQ_REG_NTR, 16'h0001);
    w(SGOQ_GRP_OPER, SGOQ_REG_ENAB, 16'h0001);
    oper_cond_in = 16'h0001;
    settle(6);
    q(SGOQ_GRP_OPER, SGOQ_REG_COND, 16'h0001);
    chk(stb_oper_summary, 1'b0);
    oper_cond_in = 16'h0000;
    settle(6);
    chk(stb_oper_summary, 1'b1);
    q(SGOQ_GRP_OPER, SGOQ_REG_EVEN, 16'h0001);
    // Fill the queue while the controller stalls, then drain it in order
    w(SGOQ_GRP_OPER, SGOQ_REG_ENAB, 16'h0010);
    ctrl.stall = 1'b1;
    fork
      begin
        ctrl.send(1'b0, SGOQ_GRP_OPER, SGOQ_REG_ENAB, 16'h0000);
        ctrl.send(1'b0, SGOQ_GRP_QUES, SGOQ_REG_ENAB, 16'h0000);
        ctrl.send(1'b0, SGOQ_GRP_POW, SGOQ_REG_ENAB, 16'h0000);
      end
    join_none
    settle(12);
    chk(message_available_flag, 1'b1);
    chk(cmd_ready, 1'b0);
    chk(resp_data, 16'h0010);
    ctrl.stall = 1'b0;
    chkpop(16'h0010);
    chkpop(16'h0008);
    chkpop(16'h0001);
    settle(3);
    chk(message_available_flag, 1'b0);
    // Clearing the queue drops words the controller never read; unused bits read zero
    oper_cond_in = 16'hffff;
    ctrl.stall = 1'b1;
    settle(4);
    ctrl.send(1'b0, SGOQ_GRP_OPER, SGOQ_REG_COND, 16'h0000);
    chk(resp_valid, 1'b1);
    chk(resp_data, SGOQ_MASK_OPER);
    oq_clear = 1'b1;
    settle(1);
    oq_clear = 1'b0;
    settle(1);
    chk(message_available_flag, 1'b0);
    chk(resp_valid, 1'b0);
    ctrl.stall = 1'b0;
    settle(4);
    chk(16'(ctrl.got.size()), 16'h0000);
    results();
  end
endmodule // testbench
